//--- acs_defines.svh
// constants of the audio clock source selector
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

`define ACS_PCLK_HZ 40000000
`define ACS_GATE_US 1000
`define ACS_GATE_CYC (`ACS_GATE_US * (`ACS_PCLK_HZ / 1000000))
`define ACS_LOSS_US 50
`define ACS_LOSS_CYC (`ACS_LOSS_US * (`ACS_PCLK_HZ / 1000000))
`define ACS_SYNC_TOL 8'h04
`define ACS_SYNC_RUN 3'h4

`define ACS_OFF_CTRL 8'h00
`define ACS_OFF_RATE 8'h04
`define ACS_OFF_STAT 8'h08
`define ACS_OFF_FREQ 8'h0C
`define ACS_OFF_CHAN 8'h10
`define ACS_OFF_IRQ_STAT 8'h14
`define ACS_OFF_IRQ_MASK 8'h18

`define ACS_CTRL_AUTO 0
`define ACS_CTRL_PREF_LO 1
`define ACS_CTRL_PREF_HI 2
`define ACS_CTRL_OPT_SPDIF 3
`define ACS_CTRL_RST 4'h1
`define ACS_RATE_RST 4'h3

`define ACS_IRQ_SRC 0
`define ACS_IRQ_LOCK 1
`define ACS_IRQ_MISMATCH 2

`define ACS_CH_ANALOG 4'h4
`define ACS_CH_AES 4'h2
`define ACS_CH_SPDIF 4'h2
`define ACS_CH_OPT_SINGLE 4'h8
`define ACS_CH_OPT_DOUBLE 4'h4
`define ACS_CH_OPT_QUAD 4'h2

`endif

//--- acs_pkg.sv
// types and rate helpers of the audio clock source selector
package acs_pkg;

  typedef enum logic [1:0] {SRC_AES, SRC_SPDIF, SRC_OPT, SRC_INT} acs_src_e;
  typedef enum logic [1:0] {IN_NO_LOCK, IN_LOCKED, IN_SYNCED} acs_in_e;
  typedef enum logic [3:0] {
    FS_NONE, FS_32K, FS_44K1, FS_48K, FS_64K, FS_88K2, FS_96K, FS_128K, FS_176K4, FS_192K
  } acs_fs_e;
  typedef enum logic [1:0] {SPD_SINGLE, SPD_DOUBLE, SPD_QUAD} acs_speed_e;
  typedef enum {ST_INTERNAL, ST_FOLLOW} acs_state_e;

  // edges counted in one millisecond gate map onto nominal rates
  function automatic acs_fs_e classify(input logic [15:0] n);
    if (n >= 16'd31 && n <= 16'd33) return FS_32K;
    else if (n >= 16'd43 && n <= 16'd45) return FS_44K1;
    else if (n >= 16'd47 && n <= 16'd49) return FS_48K;
    else if (n >= 16'd63 && n <= 16'd65) return FS_64K;
    else if (n >= 16'd87 && n <= 16'd89) return FS_88K2;
    else if (n >= 16'd95 && n <= 16'd97) return FS_96K;
    else if (n >= 16'd127 && n <= 16'd129) return FS_128K;
    else if (n >= 16'd175 && n <= 16'd178) return FS_176K4;
    else if (n >= 16'd191 && n <= 16'd193) return FS_192K;
    else return FS_NONE;
  endfunction : classify

  function automatic logic [17:0] rate_hz(input acs_fs_e f);
    case (f)
      FS_32K: return 18'd32000;
      FS_44K1: return 18'd44100;
      FS_64K: return 18'd64000;
      FS_88K2: return 18'd88200;
      FS_96K: return 18'd96000;
      FS_128K: return 18'd128000;
      FS_176K4: return 18'd176400;
      FS_192K: return 18'd192000;
      default: return 18'd48000;
    endcase
  endfunction : rate_hz

endpackage : acs_pkg

//--- acs_rate_meter.sv
// per-input sample rate meter with lock and loss detection
`timescale 1ns/1ps
`include "acs_defines.svh"
module acs_rate_meter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic edge_seen,
  input wire logic gate,
  output acs_pkg::acs_fs_e freq_r,
  output logic lock_r
);
  logic [15:0] cnt_r;
  logic [11:0] idle_r;
  logic lost;

  assign lost = (idle_r >= 12'(`ACS_LOSS_CYC));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
    end else if (ce) begin
      if (gate) cnt_r <= {15'h0000, edge_seen};
      else if (edge_seen && cnt_r != 16'hFFFF) cnt_r <= cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_r <= 12'h000;
    end else if (ce) begin
      if (edge_seen) idle_r <= 12'h000;
      else if (!lost) idle_r <= idle_r + 12'h001;
    end
  end

  // no recognised rate reads as no lock; a dead input drops lock after 50 us without an edge, without waiting for the gate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_r <= acs_pkg::FS_NONE;
      lock_r <= 1'b0;
    end else if (ce) begin
      if (lost) begin
        freq_r <= acs_pkg::FS_NONE;
        lock_r <= 1'b0;
      end else if (gate) begin
        freq_r <= acs_pkg::classify(cnt_r); // see R6
        lock_r <= (acs_pkg::classify(cnt_r) != acs_pkg::FS_NONE);
      end
    end
  end
endmodule : acs_rate_meter

//--- acs_src_model.sv
// external sources driving the recovered sample clock pins
`timescale 1ns/1ps
module acs_pin_gen #(
  parameter real OFS_NS = 0.0
) (
  input var int half_ps,
  output logic pin
);
  initial begin
    pin = 1'b0;
    #(OFS_NS);
    forever begin
      if (half_ps == 0) begin
        // stopped source: the line rests low between uses
        pin = 1'b0;
        @(half_ps);
      end else begin
        #(half_ps / 1000.0);
        pin = ~pin;
      end
    end
  end
endmodule : acs_pin_gen

////////////////////////////////////////////////////////////////////////////////
module acs_src_model (
  input var int aes_half_ps,
  input var int spdif_half_ps,
  input var int opt_half_ps,
  output logic aes_clk_pin,
  output logic spdif_clk_pin,
  output logic opt_clk_pin
);
  // each source has its own half period and start offset, so none is slaved to a common master
  acs_pin_gen #(.OFS_NS(3.7)) u_aes (.half_ps(aes_half_ps), .pin(aes_clk_pin));
  acs_pin_gen #(.OFS_NS(11.3)) u_spdif (.half_ps(spdif_half_ps), .pin(spdif_clk_pin));
  acs_pin_gen #(.OFS_NS(17.9)) u_opt (.half_ps(opt_half_ps), .pin(opt_clk_pin));
endmodule : acs_src_model

//--- acs_sync_detect.sv
// phase tracking of one locked input against the running sample clock
`timescale 1ns/1ps
`include "acs_defines.svh"
module acs_sync_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic ref_edge,
  input wire logic in_edge,
  input wire logic locked,
  output logic sync_r
);
  logic [11:0] since_r;
  logic [11:0] off_r;
  logic [2:0] run_r;
  logic [11:0] diff;

  assign diff = (since_r >= off_r) ? since_r - off_r : off_r - since_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_r <= 12'h000;
    end else if (ce) begin
      if (ref_edge) since_r <= 12'h000;
      else if (since_r != 12'hFFF) since_r <= since_r + 12'h001;
    end
  end

  // a stable offset over several samples means frequency and phase track
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_r <= 12'h000;
      run_r <= 3'h0;
      sync_r <= 1'b0;
    end else if (ce) begin
      if (!locked) begin
        run_r <= 3'h0;
        sync_r <= 1'b0;
      end else if (in_edge) begin
        off_r <= since_r;
        if (diff <= {4'h0, `ACS_SYNC_TOL}) begin
          if (run_r != `ACS_SYNC_RUN) run_r <= run_r + 3'h1;
          sync_r <= (run_r == `ACS_SYNC_RUN); // see R14
        end else begin
          run_r <= 3'h0;
          sync_r <= 1'b0;
        end
      end
    end
  end
endmodule : acs_sync_detect

//--- acs_top.sv
// audio clock source selector with status reporting and apb registers
//
// Functional notes
// R1: in automatic follow mode, scan inputs and follow a valid one's recovered clock.
// R2: when the followed reference fails, fall back to internal clock as master.
// R3: use the preferred input while valid, otherwise scan the others in turn.
// R4: with no valid input, clock mode becomes internal.
// R5: report no lock, lock or sync for each of the three inputs.
// R6: report detected rate per input and for the clock; unknown rate is no lock.
// R7: when slaved, the external rate wins over the host's configured rate.
// R8: flag a mismatch while sync source rate differs from configured rate.
// R9: double speed halves optical multichannel count from eight to four.
// R10: quad speed limits optical multichannel count to two.
// R11: analog four, aes two, spdif two channels in every speed range.
// R12: optical output in spdif mode carries no multichannel playback.
// R13: 88.2/96 is double speed, 176.4/192 quad, everything else single.
// R14: sync only when locked and tracking the selected clock in tolerance.
// R15: external sources should share one master clock to all reach sync.
`timescale 1ns/1ps
`include "acs_defines.svh"
module acs_top #(
  parameter logic [15:0] GATE_CYCLES = 16'(`ACS_GATE_CYC)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic aes_clk_pin,
  input wire logic spdif_clk_pin,
  input wire logic opt_clk_pin,
  output logic sample_tick,
  output acs_pkg::acs_src_e clk_src,
  output logic slave_mode,
  output acs_pkg::acs_speed_e speed,
  output logic two_way_sample_multiplex,
  output logic four_way_sample_multiplex,
  output logic [3:0] opt_in_chans,
  output logic [3:0] opt_out_chans,
  output logic rate_mismatch,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // input pins: two-stage synchronisers and edge detection

  logic [2:0] pin;
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic [2:0] last_r;
  logic [2:0] in_edge;
  acs_pkg::acs_fs_e in_freq [3];
  logic [2:0] in_lock;
  logic [2:0] in_sync;
  acs_pkg::acs_in_e in_state [3];
  logic gate;
  logic [15:0] gate_r;
  logic ref_edge;

  assign pin = {opt_clk_pin, spdif_clk_pin, aes_clk_pin};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
      last_r <= 3'h0;
    end else if (ce) begin
      meta_r <= pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign in_edge = sync_r & ~last_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gate_r <= 16'h0000;
    else if (ce) gate_r <= gate ? 16'h0000 : gate_r + 16'h0001;
  end

  assign gate = (gate_r >= GATE_CYCLES - 16'h0001);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_in
      acs_rate_meter u_meter (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .edge_seen(in_edge[gi]),
        .gate(gate),
        .freq_r(in_freq[gi]),
        .lock_r(in_lock[gi])
      );
      acs_sync_detect u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .ref_edge(ref_edge),
        .in_edge(in_edge[gi]),
        .locked(in_lock[gi]),
        .sync_r(in_sync[gi])
      );
      assign in_state[gi] = !in_lock[gi] ? acs_pkg::IN_NO_LOCK :
                            in_sync[gi] ? acs_pkg::IN_SYNCED : acs_pkg::IN_LOCKED; // see R5
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // registers written by software

  logic [3:0] ctrl_r;
  acs_pkg::acs_fs_e cfg_rate_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic wr_acc;
  logic rd_acc;
  logic setup;
  logic [2:0] irq_snap_r;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `ACS_CTRL_RST;
      cfg_rate_r <= acs_pkg::acs_fs_e'(`ACS_RATE_RST);
      irq_mask_r <= 3'h0;
    end else if (ce && wr_acc) begin
      if (paddr == `ACS_OFF_CTRL) ctrl_r <= pwdata[3:0];
      else if (paddr == `ACS_OFF_RATE) cfg_rate_r <= acs_pkg::acs_fs_e'(pwdata[3:0]);
      else if (paddr == `ACS_OFF_IRQ_MASK) irq_mask_r <= pwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection

  acs_pkg::acs_state_e state_r;
  acs_pkg::acs_src_e src_r;
  acs_pkg::acs_src_e pick;
  logic pick_ok;
  logic [1:0] pref;
  logic [1:0] alt1;
  logic [1:0] alt2;

  assign pref = (ctrl_r[`ACS_CTRL_PREF_HI:`ACS_CTRL_PREF_LO] > 2'd2) ? 2'd0
                : ctrl_r[`ACS_CTRL_PREF_HI:`ACS_CTRL_PREF_LO];
  assign alt1 = (pref == 2'd2) ? 2'd0 : pref + 2'd1;
  assign alt2 = (alt1 == 2'd2) ? 2'd0 : alt1 + 2'd1;

  // preferred first, then the others in turn starting after it
  always_comb begin
    pick = acs_pkg::SRC_INT;
    pick_ok = 1'b1;
    if (in_lock[pref]) pick = acs_pkg::acs_src_e'(pref); // see R3
    else if (in_lock[alt1]) pick = acs_pkg::acs_src_e'(alt1); // see R3
    else if (in_lock[alt2]) pick = acs_pkg::acs_src_e'(alt2);
    else pick_ok = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= acs_pkg::ST_INTERNAL;
      src_r <= acs_pkg::SRC_INT;
    end else if (ce) begin
      case (state_r)
        acs_pkg::ST_INTERNAL: begin
          src_r <= acs_pkg::SRC_INT;
          if (ctrl_r[`ACS_CTRL_AUTO] && pick_ok) begin
            state_r <= acs_pkg::ST_FOLLOW; // see R1
            src_r <= pick;
          end
        end
        acs_pkg::ST_FOLLOW: begin
          if (!ctrl_r[`ACS_CTRL_AUTO] || !pick_ok) begin
            state_r <= acs_pkg::ST_INTERNAL; // see R2, R4
            src_r <= acs_pkg::SRC_INT;
          end else begin
            src_r <= pick;
          end
        end
        default: begin
          state_r <= acs_pkg::ST_INTERNAL;
          src_r <= acs_pkg::SRC_INT;
        end
      endcase
    end
  end

  assign clk_src = src_r;
  assign slave_mode = (state_r == acs_pkg::ST_FOLLOW);

  ////////////////////////////////////////////////////////////////////////////
  // operating rate, internal sample clock, mismatch

  acs_pkg::acs_fs_e op_rate;
  acs_pkg::acs_fs_e ext_rate;
  logic [25:0] acc_r;
  logic [25:0] acc_sum;
  logic int_tick;
  logic tick_r;
  logic mismatch_r;

  assign ext_rate = (src_r == acs_pkg::SRC_INT) ? acs_pkg::FS_NONE : in_freq[src_r[1:0]];
  // a slaved clock runs at whatever the source feeds; host request is ignored
  assign op_rate = slave_mode ? ext_rate : cfg_rate_r; // see R7

  assign acc_sum = acc_r + {8'h00, acs_pkg::rate_hz(cfg_rate_r)};
  assign int_tick = (acc_sum >= 26'(`ACS_PCLK_HZ));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) acc_r <= 26'h0000000;
    else if (ce) acc_r <= int_tick ? acc_sum - 26'(`ACS_PCLK_HZ) : acc_sum;
  end

  assign ref_edge = slave_mode ? in_edge[src_r[1:0]] : int_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_r <= 1'b0;
    else if (ce) tick_r <= ref_edge;
  end

  assign sample_tick = tick_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mismatch_r <= 1'b0;
    else if (ce) mismatch_r <= slave_mode && (ext_rate != cfg_rate_r); // see R8
  end

  assign rate_mismatch = mismatch_r;

  ////////////////////////////////////////////////////////////////////////////
  // speed range and channel counts

  acs_pkg::acs_speed_e speed_r;
  logic [3:0] opt_in_r;
  logic [3:0] opt_out_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_r <= acs_pkg::SPD_SINGLE;
      opt_in_r <= `ACS_CH_OPT_SINGLE;
      opt_out_r <= `ACS_CH_OPT_SINGLE;
    end else if (ce) begin
      if (op_rate == acs_pkg::FS_88K2 || op_rate == acs_pkg::FS_96K) begin
        speed_r <= acs_pkg::SPD_DOUBLE; // see R13
        opt_in_r <= `ACS_CH_OPT_DOUBLE; // see R9
        opt_out_r <= ctrl_r[`ACS_CTRL_OPT_SPDIF] ? 4'h0 : `ACS_CH_OPT_DOUBLE; // see R12
      end else if (op_rate == acs_pkg::FS_176K4 || op_rate == acs_pkg::FS_192K) begin
        speed_r <= acs_pkg::SPD_QUAD; // see R13
        opt_in_r <= `ACS_CH_OPT_QUAD; // see R10
        opt_out_r <= ctrl_r[`ACS_CTRL_OPT_SPDIF] ? 4'h0 : `ACS_CH_OPT_QUAD; // see R12
      end else begin
        speed_r <= acs_pkg::SPD_SINGLE;
        opt_in_r <= `ACS_CH_OPT_SINGLE;
        opt_out_r <= ctrl_r[`ACS_CTRL_OPT_SPDIF] ? 4'h0 : `ACS_CH_OPT_SINGLE; // see R12
      end
    end
  end

  assign speed = speed_r;
  assign two_way_sample_multiplex = (speed_r == acs_pkg::SPD_DOUBLE);
  assign four_way_sample_multiplex = (speed_r == acs_pkg::SPD_QUAD);
  assign opt_in_chans = opt_in_r;
  // spdif on the optical port leaves no room for the multichannel stream
  assign opt_out_chans = opt_out_r; // see R12

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status: sticky, cleared by reading, set beats clear

  logic [2:0] ev;
  logic [2:0] lock_last_r;
  acs_pkg::acs_src_e src_last_r;
  logic mis_last_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_last_r <= 3'h0;
      src_last_r <= acs_pkg::SRC_INT;
      mis_last_r <= 1'b0;
    end else if (ce) begin
      lock_last_r <= in_lock;
      src_last_r <= src_r;
      mis_last_r <= mismatch_r;
    end
  end

  assign ev[`ACS_IRQ_SRC] = (src_r != src_last_r);
  assign ev[`ACS_IRQ_LOCK] = (in_lock != lock_last_r);
  assign ev[`ACS_IRQ_MISMATCH] = mismatch_r && !mis_last_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= 3'h0;
    end else if (ce) begin
      if (rd_acc && paddr == `ACS_OFF_IRQ_STAT) irq_stat_r <= (irq_stat_r & ~irq_snap_r) | ev;
      else irq_stat_r <= irq_stat_r | ev;
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // apb read path: data captured in the setup cycle, answered in access

  logic [31:0] rd_nxt;
  logic bad_nxt;
  logic [31:0] prdata_r;
  logic bad_r;

  always_comb begin
    rd_nxt = 32'h00000000;
    bad_nxt = 1'b0;
    if (paddr == `ACS_OFF_CTRL) rd_nxt = {28'h0000000, ctrl_r};
    else if (paddr == `ACS_OFF_RATE) rd_nxt = {28'h0000000, cfg_rate_r};
    else if (paddr == `ACS_OFF_STAT)
      rd_nxt = {22'h000000, mismatch_r, slave_mode, in_state[2], in_state[1], in_state[0], src_r};
    else if (paddr == `ACS_OFF_FREQ)
      rd_nxt = {16'h0000, op_rate, in_freq[2], in_freq[1], in_freq[0]}; // see R6
    else if (paddr == `ACS_OFF_CHAN)
      rd_nxt = {8'h00, `ACS_CH_ANALOG, `ACS_CH_AES, `ACS_CH_SPDIF, opt_out_chans, opt_in_r,
                2'b00, speed_r}; // see R11
    else if (paddr == `ACS_OFF_IRQ_STAT) rd_nxt = {29'h00000000, irq_stat_r};
    else if (paddr == `ACS_OFF_IRQ_MASK) rd_nxt = {29'h00000000, irq_mask_r};
    else bad_nxt = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      bad_r <= 1'b0;
      irq_snap_r <= 3'h0;
    end else if (ce && setup) begin
      prdata_r <= pwrite ? 32'h00000000 : rd_nxt;
      bad_r <= bad_nxt;
      irq_snap_r <= irq_stat_r;
    end
  end

  assign prdata = prdata_r;
  assign pready = psel && penable && ce;
  assign pslverr = psel && penable && bad_r;

endmodule : acs_top

//--- acs_top_assertions.sv
// concurrent checks on the ports of the clock source selector
`timescale 1ns/1ps
module acs_top_assertions #(
  parameter logic [15:0] GATE_CYCLES = 16'h9C40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sample_tick,
  input acs_pkg::acs_src_e clk_src,
  input wire logic slave_mode,
  input acs_pkg::acs_speed_e speed,
  input wire logic two_way_sample_multiplex,
  input wire logic four_way_sample_multiplex,
  input wire logic [3:0] opt_in_chans,
  input wire logic [3:0] opt_out_chans,
  input wire logic rate_mismatch
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  function automatic logic [3:0] chans(input acs_pkg::acs_speed_e s);
    return (s == acs_pkg::SPD_QUAD) ? 4'h2 : (s == acs_pkg::SPD_DOUBLE) ? 4'h4 : 4'h8;
  endfunction : chans

  sequence s_access;
    psel && penable && ce;
  endsequence
  sequence s_tick_gap;
    !sample_tick [*1];
  endsequence

  a_apb_ready: assert property (s_access |-> pready) else $error("pready missing in access");
  a_bad_addr: assert property (psel && penable && ce && paddr > 8'h18 |-> pslverr)
    else $error("no error on unmapped address");
  a_good_addr: assert property (psel && penable && ce && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped address");
  a_follow_flag: assert property ($stable(clk_src) |-> slave_mode == (clk_src != acs_pkg::SRC_INT))
    else $error("slave flag disagrees with source");
  a_two_way: assert property (two_way_sample_multiplex == (speed == acs_pkg::SPD_DOUBLE))
    else $error("two way multiplex wrong");
  a_four_way: assert property (four_way_sample_multiplex == (speed == acs_pkg::SPD_QUAD))
    else $error("four way multiplex wrong");
  a_opt_in: assert property ($stable(speed) |-> opt_in_chans == chans(speed))
    else $error("optical input channel count wrong");
  a_opt_out: assert property ($stable(speed) |-> opt_out_chans == 4'h0 || opt_out_chans == opt_in_chans)
    else $error("optical output channel count wrong");
  a_mismatch_slaved: assert property (rate_mismatch |-> slave_mode || $past(slave_mode))
    else $error("mismatch while master");
  a_tick_pulse: assert property (sample_tick |=> s_tick_gap) else $error("sample tick too long");
endmodule : acs_top_assertions

bind acs_top acs_top_assertions #(.GATE_CYCLES(GATE_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
  .paddr(paddr), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .sample_tick(sample_tick),
  .clk_src(clk_src), .slave_mode(slave_mode), .speed(speed), .two_way_sample_multiplex(two_way_sample_multiplex),
  .four_way_sample_multiplex(four_way_sample_multiplex), .opt_in_chans(opt_in_chans),
  .opt_out_chans(opt_out_chans), .rate_mismatch(rate_mismatch));

//--- acs_top_bench.sv
// self-checking bench of the audio clock source selector
`timescale 1ns/1ps
module acs_top_bench;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, sample_tick, slave_mode;
  logic two_w, four_w, rate_mismatch, irq, aes_clk_pin, spdif_clk_pin, opt_clk_pin;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, rv;
  logic [3:0] opt_in_chans, opt_out_chans;
  logic rerr;
  acs_pkg::acs_src_e clk_src;
  acs_pkg::acs_speed_e speed;
  int aes_h, spdif_h, opt_h, bad_count, num_checks, seed, s, f;
  int half_q[$] = '{100000, 50000, 25000};
  int fs_q[$] = '{3, 6, 9};

  acs_top #(.GATE_CYCLES(16'h0180)) DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .aes_clk_pin(aes_clk_pin), .spdif_clk_pin(spdif_clk_pin), .opt_clk_pin(opt_clk_pin),
    .sample_tick(sample_tick), .clk_src(clk_src), .slave_mode(slave_mode), .speed(speed),
    .two_way_sample_multiplex(two_w), .four_way_sample_multiplex(four_w), .opt_in_chans(opt_in_chans),
    .opt_out_chans(opt_out_chans), .rate_mismatch(rate_mismatch), .irq(irq));
  acs_src_model u_src (.aes_half_ps(aes_h), .spdif_half_ps(spdif_h), .opt_half_ps(opt_h),
    .aes_clk_pin(aes_clk_pin), .spdif_clk_pin(spdif_clk_pin), .opt_clk_pin(opt_clk_pin));

  ////////////////////////////////////////////////////////////////////////////////
  // reference model of speed range and channel counts
  function automatic int spd_of(input int fs);
    return (fs == 5 || fs == 6) ? 1 : (fs == 8 || fs == 9) ? 2 : 0;
  endfunction : spd_of

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    rv = $random(seed);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {rv[31:4], d[3:0]};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wt

  task automatic end_sim;
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    end_sim();
  end

  initial begin
    seed = 19781;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    {aes_h, spdif_h, opt_h, bad_count, num_checks} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    wt(1);
    chk("src", 32'(clk_src), 32'h3);
    chk("chans", {opt_in_chans, opt_out_chans, 2'h0, slave_mode, irq}, 32'h880);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", rdat, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk("rate", rdat, 32'h3);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", {rdat[30:0], rerr}, 32'h1);
    apb(1'b1, 8'h18, 32'h7);
    spdif_h = 100000;
    wt(1600);
    chk("src", 32'(clk_src), 32'h1);
    chk("slave", 32'(slave_mode), 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    chk("freq", 32'(rdat[7:0]), 32'h30);
    apb(1'b0, 8'h08, 32'h0);
    chk("stat", {rdat[5:4] != 2'h0, rdat[3:2]}, 32'h4);
    chk("irq", 32'(irq), 32'h1);
    apb(1'b1, 8'h18, 32'h0);
    wt(2);
    chk("irq", 32'(irq), 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk("irq_stat", 32'(rdat[1:0]), 32'h3);
    apb(1'b1, 8'h18, 32'h7);
    wt(2);
    chk("irq", 32'(irq), 32'h0);
    aes_h = 109091;
    wt(1600);
    chk("src", 32'(clk_src), 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk("op_rate", 32'(rdat[15:12]), 32'h2);
    chk("mismatch", 32'(rate_mismatch), 32'h1);
    apb(1'b1, 8'h04, 32'h2);
    wt(4);
    chk("mismatch", 32'(rate_mismatch), 32'h0);
    apb(1'b1, 8'h00, 32'h5);
    for (int i = 0; i < 3; i++) begin
      opt_h = half_q[i];
      f = fs_q[i];
      s = spd_of(f);
      wt(1600);
      chk("src", 32'(clk_src), 32'h2);
      chk("speed", 32'(speed), 32'(s));
      chk("mux", {two_w, four_w}, {30'h0, s == 1, s == 2});
      chk("opt_in", 32'(opt_in_chans), 32'(8 >> s));
      chk("mismatch", 32'(rate_mismatch), 32'(f != 2));
      apb(1'b0, 8'h10, 32'h0);
      chk("chan", rdat, 32'h422000 | ((8 >> s) * 32'h110) | 32'(s));
    end
    apb(1'b1, 8'h00, 32'hD);
    wt(4);
    chk("opt_out", {opt_in_chans, opt_out_chans}, 32'h20);
    apb(1'b1, 8'h00, 32'hC);
    wt(8);
    chk("src", {clk_src, slave_mode}, 32'h6);
    chk("opt_in", 32'(opt_in_chans), 32'h8);
    {aes_h, spdif_h, opt_h} = '0;
    apb(1'b1, 8'h00, 32'h1);
    wt(3200);
    chk("src", {clk_src, slave_mode}, 32'h6);
    apb(1'b0, 8'h0C, 32'h0);
    chk("freq", 32'(rdat[15:0]), 32'h2000);
    apb(1'b0, 8'h08, 32'h0);
    chk("stat", 32'(rdat[7:2]), 32'h0);
    for (int i = 0; i < 1000 && sample_tick !== 1'b1; i++) wt(1);
    chk("tick", 32'(sample_tick), 32'h1);
    end_sim();
  end
endmodule : acs_top_bench
